// [rtl/clk_mode_pkg.sv]
// Constants and types for the clock source mode control block.
// Assumes one system clock; reference clocks arrive as synchronous tick pulses.
// Function
// - Reference status bit 4 reads 0 for external, 1 for internal reference.
// - Reference status follows the select only after a domain crossing.
// - Mode status bits 3-2: FLL, bypass internal, bypass external, reserved.
// - Mode status follows source select only after synchronization.
// - Oscillator ready bit 1 sets after start-up cycles when requested.
// - Oscillator ready clears only when external enable or request clears.
// - Fine trim bit 0 lengthens period when set, shortens when cleared.
// - Seven operating states, moving only along allowed transitions.
// - Reset state is engaged internal with internal reference and debug clock.
// - Engaged modes take the output from the FLL locked at 1024 times.
// - Select 00 with external reference gives engaged external mode.
// - Select 01 internal with debug or no low power gives bypass internal.
// - Select 01 internal low power without debug disables FLL, debug clock.
// - Select 10 external with debug or no low power gives bypass external.
// - Select 10 external low power without debug disables FLL, debug clock.
// - Stop holds every generated clock static except kept-alive references.
// - Internal reference output runs in stop only with enable and stop bit.
// - External reference output runs in stop only with enable and stop bit.
// - Reference divider divides by two to its value, 000 after reset.
// - Bus divider divides by 1, 2, 4 or 8; reset value divide by 2.
// - Source select 11 is treated as 00.
// - Source change waits for new clock cycles; unavailable keeps old one.
package clk_mode_pkg;

  localparam logic [3:0] ADDR_CTRL1  = 4'h0;
  localparam logic [3:0] ADDR_CTRL2  = 4'h1;
  localparam logic [3:0] ADDR_TRIM   = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  // Control register 1 fields.
  localparam int C1_SRC_LSB   = 6;
  localparam int C1_REF_DIVIDER_LSB  = 3;
  localparam int C1_REFSEL    = 2;
  localparam int C1_IREN      = 1;
  localparam int C1_IRSTOP    = 0;
  // Control register 2 fields.
  localparam int C2_BUS_DIVIDER_LSB  = 6;
  localparam int C2_LP        = 3;
  localparam int C2_OSCREQ    = 2;
  localparam int C2_EREN      = 1;
  localparam int C2_ERSTOP    = 0;
  // Status register fields.
  localparam int ST_REFST     = 4;
  localparam int ST_MODE_LSB  = 2;
  localparam int ST_OSCRDY    = 1;
  localparam int ST_FINE_TRIM     = 0;

  localparam logic [7:0] CTRL1_RESET = 8'h04;
  localparam logic [7:0] CTRL2_RESET = 8'h40;
  localparam logic [7:0] TRIM_RESET  = 8'h80;

  localparam logic [1:0] SRC_FLL = 2'h0;
  localparam logic [1:0] SRC_INT = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SRC_RSV = 2'h3;

  // Oscillator start-up and clock switch settling, in reference edges.
  localparam int OSC_INIT_CYCLES = 4096;
  localparam int SWITCH_CYCLES   = 4;

  typedef enum logic [2:0] {
    ST_ENG_INT, ST_ENG_EXT, ST_BYP_INT, ST_BYP_INT_LP,
    ST_BYP_EXT, ST_BYP_EXT_LP, ST_STOP
  } mode_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  typedef struct packed {
    logic sys_en;
    logic dbg_en;
    logic int_ref_en;
    logic ext_ref_en;
    logic fll_en;
  } clk_gate_type;

endpackage : clk_mode_pkg

// [rtl/clock_source_mode_control.sv]
// Mode selection, status and clock gating of the clock generator.
// Assumes reference clock activity arrives as synchronous tick pulses.
//
// The placing of the registers and the strobed register port were decided locally.
module clock_source_mode_control #(
  parameter int OSC_INIT = clk_mode_pkg::OSC_INIT_CYCLES,
  parameter int SW_CYC   = clk_mode_pkg::SWITCH_CYCLES
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  // Register port
  input  wire clk_mode_pkg::bus_req_type  bus_req,
  output logic [7:0]                      rdata,
  // System conditions
  input  wire logic                       debug_active,
  input  wire logic                       stop_req,
  input  wire logic                       int_ref_tick,
  input  wire logic                       ext_ref_tick,
  // Clock control outputs
  output clk_mode_pkg::clk_gate_type      gates,
  output clk_mode_pkg::mode_type          mode,
  output logic [1:0]                      active_src,
  output logic [2:0]                      ref_divider,
  output logic [1:0]                      bus_divider,
  output logic [8:0]                      trim_code
);

  typedef struct packed {
    logic [7:0]             ctrl1;
    logic [7:0]             ctrl2;
    logic [7:0]             trim;
    logic                   fine_trim;
    logic                   osc_ready;
    logic [15:0]            osc_cnt;
    logic [1:0]             src_act;
    logic [1:0]             src_pend;
    logic [3:0]             sw_cnt;
    logic                   ref_act;
    logic [3:0]             ref_cnt;
    logic [2:0]             ref_sync;
    logic [3:0]             mode_sync;
    clk_mode_pkg::mode_type mode;
    logic [7:0]             rdata;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [1:0] src_req;
  logic       ref_sel;
  logic       lp_off;
  logic       ext_req;
  logic       new_tick;
  clk_mode_pkg::mode_type mode_next;
  logic [1:0] mode_code;

  always_comb begin
    src_req = s_q.ctrl1[clk_mode_pkg::C1_SRC_LSB +: 2];
    if (src_req == clk_mode_pkg::SRC_RSV) begin
      src_req = clk_mode_pkg::SRC_FLL;
    end
    ref_sel = s_q.ctrl1[clk_mode_pkg::C1_REFSEL];
    lp_off  = s_q.ctrl2[clk_mode_pkg::C2_LP] && !debug_active;
    ext_req = s_q.ctrl2[clk_mode_pkg::C2_EREN] ||
              (s_q.mode inside {clk_mode_pkg::ST_ENG_EXT,
                                clk_mode_pkg::ST_BYP_EXT,
                                clk_mode_pkg::ST_BYP_EXT_LP});
    case (src_req)
      clk_mode_pkg::SRC_INT: new_tick = int_ref_tick;
      clk_mode_pkg::SRC_EXT: new_tick = ext_ref_tick;
      default:               new_tick = 1'b1;
    endcase
  end

  // Mode from the active source, the reference select and low power.
  always_comb begin
    mode_next = s_q.mode;
    if (stop_req) begin
      mode_next = clk_mode_pkg::ST_STOP;
    end else begin
      case (s_q.src_act)
        clk_mode_pkg::SRC_INT: begin
          if (s_q.ref_act) begin
            mode_next = lp_off ? clk_mode_pkg::ST_BYP_INT_LP
                               : clk_mode_pkg::ST_BYP_INT;
          end
        end
        clk_mode_pkg::SRC_EXT: begin
          if (!s_q.ref_act) begin
            mode_next = lp_off ? clk_mode_pkg::ST_BYP_EXT_LP
                               : clk_mode_pkg::ST_BYP_EXT;
          end
        end
        default: begin
          mode_next = s_q.ref_act ? clk_mode_pkg::ST_ENG_INT
                                  : clk_mode_pkg::ST_ENG_EXT;
        end
      endcase
    end
  end

  always_comb begin
    case (s_q.mode)
      clk_mode_pkg::ST_BYP_INT, clk_mode_pkg::ST_BYP_INT_LP:
        mode_code = clk_mode_pkg::SRC_INT;
      clk_mode_pkg::ST_BYP_EXT, clk_mode_pkg::ST_BYP_EXT_LP:
        mode_code = clk_mode_pkg::SRC_EXT;
      default:
        mode_code = clk_mode_pkg::SRC_FLL;
    endcase
  end

  always_comb begin
    s_d = s_q;
    if (bus_req.wr) begin
      if (bus_req.addr == clk_mode_pkg::ADDR_CTRL1) begin
        s_d.ctrl1 = bus_req.wdata;
      end else if (bus_req.addr == clk_mode_pkg::ADDR_CTRL2) begin
        s_d.ctrl2 = bus_req.wdata;
      end else if (bus_req.addr == clk_mode_pkg::ADDR_TRIM) begin
        s_d.trim = bus_req.wdata;
      end else if (bus_req.addr == clk_mode_pkg::ADDR_STATUS) begin
        s_d.fine_trim = bus_req.wdata[clk_mode_pkg::ST_FINE_TRIM];
      end
    end
    // Source switch after a few cycles of the new clock.
    if (src_req != s_q.src_pend) begin
      s_d.src_pend = src_req;
      s_d.sw_cnt   = '0;
    end else if (src_req != s_q.src_act && new_tick) begin
      if (s_q.sw_cnt == 4'(SW_CYC - 1)) begin
        s_d.src_act = src_req;
        s_d.sw_cnt  = '0;
      end else begin
        s_d.sw_cnt = s_q.sw_cnt + 4'h1;
      end
    end
    // Reference select switch after a few undivided cycles of the newly selected reference.
    if (ref_sel == s_q.ref_act) begin
      s_d.ref_cnt = '0;
    end else if (ref_sel ? int_ref_tick : ext_ref_tick) begin
      if (s_q.ref_cnt == 4'(SW_CYC - 1)) begin
        s_d.ref_act = ref_sel;
        s_d.ref_cnt = '0;
      end else begin
        s_d.ref_cnt = s_q.ref_cnt + 4'h1;
      end
    end
    s_d.mode = mode_next;
    // Three-stage reference and two-stage mode synchronizers into the register domain.
    s_d.ref_sync  = {s_q.ref_sync[1:0], s_q.ref_act};
    s_d.mode_sync = {s_q.mode_sync[1:0], mode_code};
    // Oscillator start-up count.
    if (!s_d.ctrl2[clk_mode_pkg::C2_EREN] ||
        !s_d.ctrl2[clk_mode_pkg::C2_OSCREQ]) begin
      s_d.osc_ready = 1'b0;
      s_d.osc_cnt   = '0;
    end else if (ext_req && !s_q.osc_ready && ext_ref_tick) begin
      if (s_q.osc_cnt == 16'(OSC_INIT - 1)) begin
        s_d.osc_ready = 1'b1;
      end else begin
        s_d.osc_cnt = s_q.osc_cnt + 16'h1;
      end
    end
    s_d.rdata = '0;
    if (bus_req.rd) begin
      if (bus_req.addr == clk_mode_pkg::ADDR_CTRL1) begin
        s_d.rdata = s_q.ctrl1;
      end else if (bus_req.addr == clk_mode_pkg::ADDR_CTRL2) begin
        s_d.rdata = s_q.ctrl2;
      end else if (bus_req.addr == clk_mode_pkg::ADDR_TRIM) begin
        s_d.rdata = s_q.trim;
      end else if (bus_req.addr == clk_mode_pkg::ADDR_STATUS) begin
        s_d.rdata = {3'h0, s_q.ref_sync[2], s_q.mode_sync[3:2],
                     s_q.osc_ready, s_q.fine_trim};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q.ctrl1     <= clk_mode_pkg::CTRL1_RESET;
      s_q.ctrl2     <= clk_mode_pkg::CTRL2_RESET;
      s_q.trim      <= clk_mode_pkg::TRIM_RESET;
      s_q.fine_trim <= 1'b0;
      s_q.osc_ready <= 1'b0;
      s_q.osc_cnt   <= '0;
      s_q.src_act   <= clk_mode_pkg::SRC_FLL;
      s_q.src_pend  <= clk_mode_pkg::SRC_FLL;
      s_q.sw_cnt    <= '0;
      s_q.ref_act   <= 1'b1;
      s_q.ref_cnt   <= '0;
      s_q.ref_sync  <= 3'h7;
      s_q.mode_sync <= 4'h0;
      s_q.mode      <= clk_mode_pkg::ST_ENG_INT;
      s_q.rdata     <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  logic stopped;
  assign stopped = (s_q.mode == clk_mode_pkg::ST_STOP);

  always_comb begin
    gates.sys_en = !stopped;
    gates.fll_en = !stopped &&
      !(s_q.mode inside {clk_mode_pkg::ST_BYP_INT_LP,
                         clk_mode_pkg::ST_BYP_EXT_LP});
    gates.dbg_en = gates.fll_en;
    gates.int_ref_en = stopped ?
      (s_q.ctrl1[clk_mode_pkg::C1_IREN] &&
       s_q.ctrl1[clk_mode_pkg::C1_IRSTOP]) :
      s_q.ctrl1[clk_mode_pkg::C1_IREN];
    gates.ext_ref_en = stopped ?
      (s_q.ctrl2[clk_mode_pkg::C2_EREN] &&
       s_q.ctrl2[clk_mode_pkg::C2_ERSTOP]) :
      s_q.ctrl2[clk_mode_pkg::C2_EREN];
  end

  assign rdata       = s_q.rdata;
  assign mode        = s_q.mode;
  assign active_src  = s_q.src_act;
  assign ref_divider = s_q.ctrl1[clk_mode_pkg::C1_REF_DIVIDER_LSB +: 3];
  assign bus_divider = s_q.ctrl2[clk_mode_pkg::C2_BUS_DIVIDER_LSB +: 2];
  assign trim_code   = {s_q.trim, s_q.fine_trim};

  chk_status_lag: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(s_q.ref_act) |=> !$changed(s_q.ref_sync[2]) ##1
      1'b1 ##1 (s_q.ref_sync[2] == $past(s_q.ref_act, 3)))
    else $error("reference status not lagging");
  chk_reserved_src: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.src_pend != clk_mode_pkg::SRC_RSV)
    else $error("reserved source pending");
  chk_stop_gates: assert property (@(posedge clk_sys) disable iff (srst)
    stopped |-> !gates.sys_en && !gates.dbg_en && !gates.fll_en)
    else $error("clock running in stop");
  chk_int_stop: assert property (@(posedge clk_sys) disable iff (srst)
    stopped && !s_q.ctrl1[clk_mode_pkg::C1_IRSTOP] |-> !gates.int_ref_en)
    else $error("internal reference running in stop");
  chk_ext_stop: assert property (@(posedge clk_sys) disable iff (srst)
    stopped && !s_q.ctrl2[clk_mode_pkg::C2_ERSTOP] |-> !gates.ext_ref_en)
    else $error("external reference running in stop");
  chk_osc_clear: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(s_q.osc_ready) |-> !s_q.ctrl2[clk_mode_pkg::C2_EREN] ||
      !s_q.ctrl2[clk_mode_pkg::C2_OSCREQ])
    else $error("oscillator ready cleared wrongly");
  chk_lowpwr_fll: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.mode == clk_mode_pkg::ST_BYP_INT_LP |-> !gates.fll_en && !gates.dbg_en)
    else $error("fll on in low power");
  chk_source_settle: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(s_q.src_act) |-> $past(new_tick))
    else $error("source switched without new clock");
  cov_bypass_int: cover property (@(posedge clk_sys)
    s_q.mode == clk_mode_pkg::ST_BYP_INT);
  cov_eng_ext: cover property (@(posedge clk_sys)
    s_q.mode == clk_mode_pkg::ST_ENG_EXT);
  cov_osc_ready: cover property (@(posedge clk_sys) $rose(s_q.osc_ready));
  cov_stop_mode: cover property (@(posedge clk_sys)
    s_q.mode == clk_mode_pkg::ST_STOP);
  cov_bypass_ext_lp: cover property (@(posedge clk_sys)
    s_q.mode == clk_mode_pkg::ST_BYP_EXT_LP);

  chk_status_zero: assert property (@(posedge clk_sys) disable iff (srst)
    $past(bus_req.rd) && $past(bus_req.addr) == clk_mode_pkg::ADDR_STATUS
    |-> rdata[7:5] == 3'h0)
    else $error("reserved status bits not zero");

  chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (srst)
    !$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data not idle");

  chk_ref_status_bit: assert property (@(posedge clk_sys) disable iff (srst)
    $past(bus_req.rd) && $past(bus_req.addr) == clk_mode_pkg::ADDR_STATUS
    |-> rdata[clk_mode_pkg::ST_REFST] == $past(s_q.ref_sync[2]))
    else $error("reference status bit wrong");

  chk_mode_status_field: assert property (@(posedge clk_sys) disable iff (srst)
    $past(bus_req.rd) && $past(bus_req.addr) == clk_mode_pkg::ADDR_STATUS
    |-> rdata[3:2] == $past(s_q.mode_sync[3:2]))
    else $error("mode status field wrong");

  chk_mode_code_range: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.mode_sync[1:0] != clk_mode_pkg::SRC_RSV)
    else $error("reserved mode status code");

  chk_src_never_rsv: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.src_act != clk_mode_pkg::SRC_RSV)
    else $error("reserved source active");

  chk_fll_engaged: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.mode inside {clk_mode_pkg::ST_ENG_INT, clk_mode_pkg::ST_ENG_EXT}
    |-> gates.fll_en && gates.sys_en)
    else $error("fll off in engaged mode");

  chk_lowpwr_ext: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.mode == clk_mode_pkg::ST_BYP_EXT_LP |-> !gates.fll_en && !gates.dbg_en)
    else $error("fll on in external low power");

  chk_bypass_int_fll: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.mode == clk_mode_pkg::ST_BYP_INT |-> gates.fll_en && gates.dbg_en)
    else $error("fll off in internal bypass");

  chk_bypass_ext_fll: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.mode == clk_mode_pkg::ST_BYP_EXT |-> gates.fll_en && gates.dbg_en)
    else $error("fll off in external bypass");

  chk_osc_ready_req: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.osc_ready |-> s_q.ctrl2[clk_mode_pkg::C2_EREN] &&
      s_q.ctrl2[clk_mode_pkg::C2_OSCREQ])
    else $error("oscillator ready without request");

  chk_stop_entry: assert property (@(posedge clk_sys) disable iff (srst)
    stop_req |=> s_q.mode == clk_mode_pkg::ST_STOP)
    else $error("stop not entered");

  chk_stop_exit: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.mode == clk_mode_pkg::ST_STOP |-> $past(stop_req))
    else $error("stop held without request");

  chk_int_run: assert property (@(posedge clk_sys) disable iff (srst)
    !stopped |-> gates.int_ref_en == s_q.ctrl1[clk_mode_pkg::C1_IREN])
    else $error("internal reference gate wrong");

  chk_ext_run: assert property (@(posedge clk_sys) disable iff (srst)
    !stopped |-> gates.ext_ref_en == s_q.ctrl2[clk_mode_pkg::C2_EREN])
    else $error("external reference gate wrong");

  chk_mode_sync_stage: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.mode_sync[3:2] == $past(s_q.mode_sync[1:0]))
    else $error("mode synchronizer stage skipped");

  chk_ref_sync_stage: assert property (@(posedge clk_sys) disable iff (srst)
    s_q.ref_sync[2:1] == $past(s_q.ref_sync[1:0]))
    else $error("reference synchronizer stage skipped");

  chk_switch_pend: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(s_q.src_act) |-> s_q.src_act == $past(s_q.src_pend))
    else $error("source switched to unsettled request");

  chk_switch_count: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(s_q.src_act) |-> $past(s_q.sw_cnt) == 4'(SW_CYC - 1))
    else $error("source switched before settling count");

endmodule : clock_source_mode_control

// [sim/ref_tick_model.sv]
// Reference source model: tick pulses of the internal and external clocks.
// Assumes the bench clock and a synchronous active-high reset.
module ref_tick_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Source control
  input  wire logic ext_present,
  // Reference ticks
  output logic      int_ref_tick,
  output logic      ext_ref_tick
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] int_cnt_q;
  logic [2:0] ext_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_cnt_q <= 3'h0;
      ext_cnt_q <= 3'h0;
    end else begin
      int_cnt_q <= (int_cnt_q == 3'h4) ? 3'h0 : int_cnt_q + 3'h1;
      ext_cnt_q <= (ext_cnt_q == 3'h6) ? 3'h0 : ext_cnt_q + 3'h1;
    end
  end

  assign int_ref_tick = (int_cnt_q == 3'h4);
  // A missing external source gives no ticks at all.
  assign ext_ref_tick = ext_present && (ext_cnt_q == 3'h6);
endmodule : ref_tick_model

// [sim/clock_source_mode_control_tb.sv]
// Self-checking bench of the clock source mode control block.
// Assumes the reference tick model and the design package are compiled.
`define chk_eq(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  miscompares++; $display("ERROR %0t: got %0h expected %0h", $time, g, e); \
  end end
module clock_source_mode_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                      clk_sys = 1'b0;
  logic                      srst;
  clk_mode_pkg::bus_req_type bus_req;
  logic [7:0]                rdata;
  logic                      debug_active;
  logic                      stop_req;
  logic                      ext_present;
  logic                      int_ref_tick;
  logic                      ext_ref_tick;
  clk_mode_pkg::clk_gate_type gates;
  clk_mode_pkg::mode_type    mode;
  logic [1:0]                active_src;
  logic [2:0]                ref_divider;
  logic [1:0]                bus_divider;
  logic [8:0]                trim_code;
  int                        miscompares = 0;
  int                        cmp_count = 0;
  int                        cyc = 0;
  logic [7:0]                tbl [5] = '{8'h04, 8'h00, 8'h44, 8'h80, 8'hc4};

  always #5 clk_sys = ~clk_sys;

  clock_source_mode_control #(.OSC_INIT(8), .SW_CYC(4)) dut_u (
    .clk_sys(clk_sys), .srst(srst), .bus_req(bus_req), .rdata(rdata),
    .debug_active(debug_active), .stop_req(stop_req),
    .int_ref_tick(int_ref_tick), .ext_ref_tick(ext_ref_tick),
    .gates(gates), .mode(mode), .active_src(active_src),
    .ref_divider(ref_divider), .bus_divider(bus_divider),
    .trim_code(trim_code)
  );

  ref_tick_model src_u (
    .clk_sys(clk_sys), .srst(srst), .ext_present(ext_present),
    .int_ref_tick(int_ref_tick), .ext_ref_tick(ext_ref_tick)
  );

  function automatic clk_mode_pkg::mode_type exp_mode(input logic [7:0] c1,
      input logic lp, input logic dbg);
    case (c1[7:6])
      2'h1: exp_mode = (lp && !dbg) ? clk_mode_pkg::ST_BYP_INT_LP
                                    : clk_mode_pkg::ST_BYP_INT;
      2'h2: exp_mode = (lp && !dbg) ? clk_mode_pkg::ST_BYP_EXT_LP
                                    : clk_mode_pkg::ST_BYP_EXT;
      default: exp_mode = c1[2] ? clk_mode_pkg::ST_ENG_INT
                                : clk_mode_pkg::ST_ENG_EXT;
    endcase
  endfunction : exp_mode

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic wait_mode(input clk_mode_pkg::mode_type m);
    int n;
    n = 0;
    while (mode !== m && n < 300) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `chk_eq(mode, m);
    repeat (4) @(posedge clk_sys);
  endtask : wait_mode

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    logic [7:0] d;
    logic [7:0] c1;
    logic [7:0] prev_st;
    logic [7:0] t;
    logic       lp;
    logic       dbg;
    int         n;
    bus_req = '0;
    debug_active = 1'b0;
    stop_req = 1'b0;
    ext_present = 1'b1;
    srst = 1'b1;
    t = 8'($urandom(64691));
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    rd_reg(clk_mode_pkg::ADDR_CTRL1, d);
    `chk_eq(d, 8'h04);
    rd_reg(clk_mode_pkg::ADDR_CTRL2, d);
    `chk_eq(d, 8'h40);
    rd_reg(clk_mode_pkg::ADDR_STATUS, d);
    `chk_eq(d, 8'h10);
    `chk_eq(mode, clk_mode_pkg::ST_ENG_INT);
    `chk_eq({ref_divider, bus_divider}, 5'h01);
    `chk_eq({gates.dbg_en, gates.fll_en}, 2'h3);
    $display("test reset done");
    prev_st = 8'h10;
    for (int i = 0; i < 20; i++) begin
      c1 = tbl[i % 5] | {2'h0, 3'($urandom), 3'h0};
      lp = (i / 5) % 2;
      dbg = (i / 10);
      debug_active <= dbg;
      d = {2'($urandom), 2'h0, lp, 3'h0};
      wr_reg(clk_mode_pkg::ADDR_CTRL2, d);
      `chk_eq(bus_divider, d[7:6]);
      wr_reg(clk_mode_pkg::ADDR_CTRL1, c1);
      rd_reg(clk_mode_pkg::ADDR_STATUS, d);
      `chk_eq(d, prev_st);
      wait_mode(exp_mode(c1, lp, dbg));
      prev_st = {3'h0, c1[2], (c1[7:6] == 2'h3) ? 2'h0 : c1[7:6], 2'h0};
      rd_reg(clk_mode_pkg::ADDR_STATUS, d);
      `chk_eq(d, prev_st);
      `chk_eq(ref_divider, c1[5:3]);
      n = (c1[7:6] == 2'h1 || c1[7:6] == 2'h2) && lp && !dbg;
      `chk_eq({gates.fll_en, gates.dbg_en}, {2{!n[0]}});
    end
    $display("test modes done");
    ext_present <= 1'b0;
    wr_reg(clk_mode_pkg::ADDR_CTRL1, 8'h80);
    repeat (100) @(posedge clk_sys);
    `chk_eq(mode, clk_mode_pkg::ST_ENG_INT);
    ext_present <= 1'b1;
    wait_mode(clk_mode_pkg::ST_BYP_EXT);
    wr_reg(clk_mode_pkg::ADDR_CTRL1, 8'h04);
    wait_mode(clk_mode_pkg::ST_ENG_INT);
    $display("test absent source done");
    foreach (tbl[k]) begin
      if (k < 2) begin
        wr_reg(clk_mode_pkg::ADDR_CTRL2, 8'h46);
        n = 0;
        d = 8'h00;
        while (!d[1] && n < 40) begin
          rd_reg(clk_mode_pkg::ADDR_STATUS, d);
          n++;
        end
        `chk_eq(d[1], 1'b1);
        wr_reg(clk_mode_pkg::ADDR_CTRL2, k ? 8'h42 : 8'h44);
        rd_reg(clk_mode_pkg::ADDR_STATUS, d);
        `chk_eq(d[1], 1'b0);
      end
    end
    $display("test oscillator done");
    wr_reg(clk_mode_pkg::ADDR_TRIM, t);
    wr_reg(clk_mode_pkg::ADDR_STATUS, 8'hff);
    rd_reg(clk_mode_pkg::ADDR_STATUS, d);
    `chk_eq(d, 8'h11);
    `chk_eq(trim_code, {t, 1'b1});
    wr_reg(clk_mode_pkg::ADDR_STATUS, 8'h00);
    `chk_eq(trim_code, {t, 1'b0});
    $display("test trim done");
    wr_reg(clk_mode_pkg::ADDR_CTRL1, 8'h07);
    wr_reg(clk_mode_pkg::ADDR_CTRL2, 8'h43);
    stop_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `chk_eq(mode, clk_mode_pkg::ST_STOP);
    `chk_eq(gates, 5'b00110);
    wr_reg(clk_mode_pkg::ADDR_CTRL1, 8'h06);
    wr_reg(clk_mode_pkg::ADDR_CTRL2, 8'h42);
    #1;
    `chk_eq(gates, 5'b00000);
    stop_req <= 1'b0;
    wait_mode(clk_mode_pkg::ST_ENG_INT);
    $display("test stop done");
    rd_reg(4'h9, d);
    `chk_eq(d, 8'h00);
    wr_reg(4'h9, 8'hff);
    rd_reg(clk_mode_pkg::ADDR_CTRL1, d);
    `chk_eq(d, 8'h06);
    @(posedge clk_sys);
    #1;
    `chk_eq(rdata, 8'h00);
    $display("test unmapped done");
    wrap_up();
  end
endmodule : clock_source_mode_control_tb
